/* File: logic/erp_event_report.sv */
/*
 * Event-report power-control register with set and clear aliases, and the
 * edge detectors whose reports it enables.
 * Assumes the ULPI framer issues register accesses as one-cycle strobes and
 * pulses rx_cmd_ack at the turnaround where it sends the pending RX CMD.
 * Status pulses shorter than one clock may be missed, since only levels are sampled.
 */
`timescale 1ns/1ps

module erp_event_report (
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  input  wire erp_pkg::erp_reg_req_t         reg_req,
  output logic [erp_pkg::ERP_DATA_W-1:0]     rd_data_reg,
  output logic                               rd_valid_reg,
  output logic [erp_pkg::ERP_DATA_W-1:0]     ctrl_reg,
  input  wire erp_pkg::erp_monitor_t         monitor_in,
  output logic                               rx_cmd_req_reg,
  output logic                               rx_cmd_alt_int_reg,
  input  wire logic                          rx_cmd_ack
);
  import erp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////

  logic                  hit_ctrl;
  logic                  hit_set;
  logic                  hit_clr;
  logic                  hit_any;
  logic [ERP_DATA_W-1:0] ctrl_next;
  logic [ERP_DATA_W-1:0] rd_data_next;

  assign hit_ctrl = reg_req.addr == ERP_OFS_CTRL;
  assign hit_set  = reg_req.addr == ERP_OFS_SET;
  assign hit_clr  = reg_req.addr == ERP_OFS_CLR;
  assign hit_any  = hit_ctrl | hit_set | hit_clr;

  // Spare bits are stored like the rest; keeping them zero is up to the link.
  assign ctrl_next = !reg_req.wr_en ? ctrl_reg                        :
                     hit_ctrl       ? reg_req.wdata                   :
                     hit_set        ? (ctrl_reg | reg_req.wdata)      :
                     hit_clr        ? (ctrl_reg & ~reg_req.wdata)     :
                                      ctrl_reg;

  // All three offsets read the one register; anything else reads zero.
  assign rd_data_next = hit_any ? ctrl_reg : ERP_RD_ZERO;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_reg     <= ERP_CTRL_RESET;
      rd_data_reg  <= ERP_RD_ZERO;
      rd_valid_reg <= 1'b0;
    end else begin
      ctrl_reg     <= ctrl_next;
      rd_data_reg  <= reg_req.rd_en ? rd_data_next : rd_data_reg;
      rd_valid_reg <= reg_req.rd_en;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Stage one feeds only stage two; edges compare stage two with stage three.
  // The stages reset to zero, so an input already high at release looks like a rising
  // edge two or three cycles later; it is reported only if its enable is set by then.
  erp_monitor_t mon_meta_reg;
  erp_monitor_t mon_sync_reg;
  erp_monitor_t mon_prev_reg;
  erp_monitor_t mon_diff;
  logic         ev_supply;
  logic         ev_idfloat;
  logic         ev_idres;
  logic         ev_bfall;
  logic         ev_brise;
  logic         ev_stress;
  logic         ev_alt;
  logic         ev_any;
  logic         req_next;
  logic         alt_next;

  assign mon_diff   = mon_sync_reg ^ mon_prev_reg;
  assign ev_supply  = ctrl_reg[ERP_BIT_SUPPLY_EN] & mon_diff.supply_ok_monitor;
  assign ev_idfloat = ctrl_reg[ERP_BIT_IDFLOAT_EN] & mon_diff.id_pin_floating;
  assign ev_idres   = ctrl_reg[ERP_BIT_IDRES_EN] & (mon_diff.id_resistor_detect_a |
                      mon_diff.id_resistor_detect_b | mon_diff.id_resistor_detect_c);
  assign ev_bfall   = ctrl_reg[ERP_BIT_BFALL_EN] & mon_prev_reg.b_session_valid &
                      ~mon_sync_reg.b_session_valid;
  assign ev_brise   = ctrl_reg[ERP_BIT_BRISE_EN] & ~mon_prev_reg.b_session_valid &
                      mon_sync_reg.b_session_valid;
  assign ev_stress  = ctrl_reg[ERP_BIT_STRESS_EN] & mon_diff.abnormal_stress_flag;
  assign ev_alt     = ev_bfall | ev_brise;
  assign ev_any     = ev_supply | ev_idfloat | ev_idres | ev_alt | ev_stress;

  // A new event in the acknowledge cycle stays pending, so none is lost.
  // Events arriving while one is pending merge into that single report.
  assign req_next = (rx_cmd_req_reg & ~rx_cmd_ack) | ev_any;
  assign alt_next = (rx_cmd_alt_int_reg & ~rx_cmd_ack) | ev_alt;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mon_meta_reg       <= '0;
      mon_sync_reg       <= '0;
      mon_prev_reg       <= '0;
      rx_cmd_req_reg     <= 1'b0;
      rx_cmd_alt_int_reg <= 1'b0;
    end else begin
      mon_meta_reg       <= monitor_in;
      mon_sync_reg       <= mon_meta_reg;
      mon_prev_reg       <= mon_sync_reg;
      rx_cmd_req_reg     <= req_next;
      rx_cmd_alt_int_reg <= alt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  default clocking chk_cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  chk_reset_zero: assert property ($past(sys_rst) |-> ctrl_reg == ERP_CTRL_RESET)
    else $error("control register not zero after reset");
  chk_set_alias: assert property (reg_req.wr_en && hit_set |=>
    ctrl_reg == ($past(ctrl_reg) | $past(reg_req.wdata)))
    else $error("set alias did not OR in written ones");
  chk_clr_alias: assert property (reg_req.wr_en && hit_clr |=>
    ctrl_reg == ($past(ctrl_reg) & ~$past(reg_req.wdata)))
    else $error("clear alias did not remove written ones");
  chk_alias_read: assert property (reg_req.rd_en && (hit_set || hit_clr) |=>
    rd_valid_reg && rd_data_reg == $past(ctrl_reg))
    else $error("alias read did not return the register");
  chk_supply_report: assert property (ctrl_reg[ERP_BIT_SUPPLY_EN] &&
    mon_sync_reg.supply_ok_monitor != mon_prev_reg.supply_ok_monitor |=> rx_cmd_req_reg)
    else $error("supply-ok edge not reported");
  chk_idfloat_report: assert property (ctrl_reg[ERP_BIT_IDFLOAT_EN] &&
    $changed(mon_sync_reg.id_pin_floating) |=> rx_cmd_req_reg)
    else $error("id floating edge not reported");
  chk_idres_report: assert property (ctrl_reg[ERP_BIT_IDRES_EN] &&
    ($changed(mon_sync_reg.id_resistor_detect_a) || $changed(mon_sync_reg.id_resistor_detect_b) ||
    $changed(mon_sync_reg.id_resistor_detect_c)) |=> rx_cmd_req_reg)
    else $error("id resistor edge not reported");
  chk_bfall_alt: assert property (ctrl_reg[ERP_BIT_BFALL_EN] &&
    $fell(mon_sync_reg.b_session_valid) |=> rx_cmd_req_reg && rx_cmd_alt_int_reg)
    else $error("session-valid fall not reported with alt_int");
  chk_brise_alt: assert property (ctrl_reg[ERP_BIT_BRISE_EN] && mon_sync_reg.b_session_valid &&
    !mon_prev_reg.b_session_valid |=> rx_cmd_req_reg && rx_cmd_alt_int_reg)
    else $error("session-valid rise not reported with alt_int");
  chk_stress_report: assert property (ctrl_reg[ERP_BIT_STRESS_EN] &&
    $changed(mon_sync_reg.abnormal_stress_flag) |=> rx_cmd_req_reg)
    else $error("abnormal stress edge not reported");
  chk_pending_hold: assert property (rx_cmd_req_reg && !rx_cmd_ack |=> rx_cmd_req_reg)
    else $error("pending report dropped without acknowledge");
  chk_quiet_off: assert property (ctrl_reg == ERP_CTRL_RESET && !rx_cmd_req_reg |=> !rx_cmd_req_reg)
    else $error("report raised with all enables off");
  chk_bfall_no_rise: assert property (ctrl_reg[ERP_BIT_BFALL_EN] && !ctrl_reg[ERP_BIT_BRISE_EN] &&
    $rose(mon_sync_reg.b_session_valid) && !rx_cmd_alt_int_reg |=> !rx_cmd_alt_int_reg)
    else $error("session-valid rise flagged with only the fall enable set");
  chk_brise_no_fall: assert property (ctrl_reg[ERP_BIT_BRISE_EN] && !ctrl_reg[ERP_BIT_BFALL_EN] &&
    $fell(mon_sync_reg.b_session_valid) && !rx_cmd_alt_int_reg |=> !rx_cmd_alt_int_reg)
    else $error("session-valid fall flagged with only the rise enable set");

  // Register port: only a mapped write moves the register, and every read strobe is
  // answered by exactly one valid pulse.
  chk_ctrl_write: assert property (reg_req.wr_en && hit_ctrl |=>
    ctrl_reg == $past(reg_req.wdata))
    else $error("direct write did not load the register");
  chk_ctrl_hold: assert property (!(reg_req.wr_en && hit_any) |=>
    $stable(ctrl_reg))
    else $error("register changed without a mapped write");
  chk_ctrl_read: assert property (reg_req.rd_en && hit_ctrl |=>
    rd_valid_reg && rd_data_reg == $past(ctrl_reg))
    else $error("direct read did not return the register");
  chk_unmapped_read: assert property (reg_req.rd_en && !hit_any |=>
    rd_valid_reg && rd_data_reg == ERP_RD_ZERO)
    else $error("unmapped read did not return zero");
  chk_rd_pulse: assert property (!reg_req.rd_en |=>
    !rd_valid_reg)
    else $error("read valid without a read strobe");
  chk_rd_hold: assert property (!reg_req.rd_en |=>
    $stable(rd_data_reg))
    else $error("read data changed without a read strobe");

  // Report path: reset leaves nothing pending, only session-valid edges carry alt_int,
  // and an event in the acknowledge cycle wins over the clear so that it is not lost.
  chk_reset_report: assert property ($past(sys_rst) |->
    !rx_cmd_req_reg && !rx_cmd_alt_int_reg && !rd_valid_reg)
    else $error("report or read pending after reset");
  chk_alt_source: assert property (!ev_alt && (!rx_cmd_alt_int_reg || rx_cmd_ack) |=>
    !rx_cmd_alt_int_reg)
    else $error("alt_int raised without a session-valid edge");
  chk_alt_with_req: assert property (rx_cmd_alt_int_reg |->
    rx_cmd_req_reg)
    else $error("alt_int standing without a pending report");
  chk_ack_release: assert property (rx_cmd_req_reg && rx_cmd_ack && !ev_any |=>
    !rx_cmd_req_reg && !rx_cmd_alt_int_reg)
    else $error("acknowledged report still pending");
  chk_ack_set_wins: assert property (rx_cmd_ack && ev_any |=>
    rx_cmd_req_reg)
    else $error("event in acknowledge cycle was lost");
  chk_no_spurious: assert property (!ev_any && (!rx_cmd_req_reg || rx_cmd_ack) |=>
    !rx_cmd_req_reg)
    else $error("report raised without an enabled edge");

  // Main scenarios: alias writes, session-valid reports, acknowledge races and merging.
  cov_set_write: cover property (reg_req.wr_en && hit_set);
  cov_alt_report: cover property (rx_cmd_req_reg && rx_cmd_alt_int_reg ##1 rx_cmd_ack);
  cov_ack_with_event: cover property (rx_cmd_req_reg && rx_cmd_ack && ev_any);
  cov_clr_write: cover property (reg_req.wr_en && hit_clr);
  cov_merge_pending: cover property (rx_cmd_req_reg && !rx_cmd_ack && ev_any);

endmodule : erp_event_report

/* File: logic/erp_pkg.sv */
/*
 * Constants and types for the event-report power-control register bank.
 * Assumes an 8-bit register access port and a single ULPI-side clock.
 */
package erp_pkg;

  localparam int unsigned ERP_ADDR_W = 8;
  localparam int unsigned ERP_DATA_W = 8;

  // Register offsets: direct, set alias and clear alias.
  localparam logic [ERP_ADDR_W-1:0] ERP_OFS_CTRL = 8'h3d;
  localparam logic [ERP_ADDR_W-1:0] ERP_OFS_SET  = 8'h3e;
  localparam logic [ERP_ADDR_W-1:0] ERP_OFS_CLR  = 8'h3f;

  localparam logic [ERP_DATA_W-1:0] ERP_CTRL_RESET = 8'h00;
  localparam logic [ERP_DATA_W-1:0] ERP_RD_ZERO    = 8'h00;

  // Field positions inside the control register.
  localparam int unsigned ERP_BIT_SPARE_HI   = 7;
  localparam int unsigned ERP_BIT_SUPPLY_EN  = 6;
  localparam int unsigned ERP_BIT_IDFLOAT_EN = 5;
  localparam int unsigned ERP_BIT_IDRES_EN   = 4;
  localparam int unsigned ERP_BIT_BFALL_EN   = 3;
  localparam int unsigned ERP_BIT_BRISE_EN   = 2;
  localparam int unsigned ERP_BIT_SPARE_LO   = 1;
  localparam int unsigned ERP_BIT_STRESS_EN  = 0;

  // Monitored status signals, all asynchronous to the ULPI clock.
  typedef struct packed {
    logic supply_ok_monitor;
    logic id_pin_floating;
    logic id_resistor_detect_a;
    logic id_resistor_detect_b;
    logic id_resistor_detect_c;
    logic b_session_valid;
    logic abnormal_stress_flag;
  } erp_monitor_t;

  // One register access from the link side.
  typedef struct packed {
    logic                  wr_en;
    logic                  rd_en;
    logic [ERP_ADDR_W-1:0] addr;
    logic [ERP_DATA_W-1:0] wdata;
  } erp_reg_req_t;

endpackage : erp_pkg

/* File: bench/erp_link_model.sv */
/* Link-side partner: acknowledges pending RX CMD reports.
   Assumes one clock and a one-cycle ack, delayed by ack_delay. */
`timescale 1ns/1ps
module erp_link_model (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] ack_delay,
  input  wire logic       rx_cmd_req_reg,
  output logic            rx_cmd_ack
);
  initial rx_cmd_ack = 1'b0;
  // Acks only a pending report, so the framer never sends one twice.
  always begin
    @(negedge sys_clk);
    if (!sys_rst && rx_cmd_req_reg === 1'b1) begin
      repeat (ack_delay) @(negedge sys_clk);
      rx_cmd_ack = 1'b1;
      @(negedge sys_clk);
      rx_cmd_ack = 1'b0;
    end
  end
endmodule : erp_link_model

/* File: bench/erp_event_report_tb.sv */
/* Testbench for the event-report power-control register bank.
   Assumes the link model answers reports; inputs change on falling edges. */
`timescale 1ns/1ps
module erp_event_report_tb;
  import erp_pkg::*;
  logic         sys_clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         rx_cmd_ack;
  erp_reg_req_t reg_req = '0;
  erp_monitor_t monitor_in = '0;
  logic [7:0]   rd_data_reg;
  logic [7:0]   ctrl_reg;
  logic         rd_valid_reg;
  logic         rx_cmd_req_reg;
  logic         rx_cmd_alt_int_reg;
  logic [3:0]   ack_delay = 4'h0;
  int           err_count = 0;
  int           tests_run = 0;
  int           ren[7] = '{0, 2, 4, 4, 4, 5, 6};
  int           fen[7] = '{0, 3, 4, 4, 4, 5, 6};
  always #4 sys_clk = ~sys_clk;
  erp_event_report dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req), .rd_data_reg(rd_data_reg),
    .rd_valid_reg(rd_valid_reg), .ctrl_reg(ctrl_reg), .monitor_in(monitor_in), .rx_cmd_req_reg(rx_cmd_req_reg),
    .rx_cmd_alt_int_reg(rx_cmd_alt_int_reg), .rx_cmd_ack(rx_cmd_ack));
  erp_link_model link_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .ack_delay(ack_delay),
    .rx_cmd_req_reg(rx_cmd_req_reg), .rx_cmd_ack(rx_cmd_ack));
  ////////////////////////////////////////////////////////////////////////////
  task automatic ck(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : ck
  // Spare bits are masked because the link never writes ones there.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req.wr_en = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d & 8'h7d;
    @(negedge sys_clk);
    reg_req.wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_req.rd_en = 1'b1;
    reg_req.addr = a;
    @(negedge sys_clk);
    reg_req.rd_en = 1'b0;
    ck(rd_valid_reg === 1'b1 && rd_data_reg === exp, "read data");
  endtask : rd
  task automatic t_regs;
    ck(ctrl_reg === ERP_CTRL_RESET, "reset value");
    rd(ERP_OFS_CTRL, 8'h00);
    wr(ERP_OFS_CTRL, 8'h24);
    wr(ERP_OFS_SET, 8'h41);
    ck(ctrl_reg === 8'h65, "set alias");
    wr(ERP_OFS_CLR, 8'h24);
    ck(ctrl_reg === 8'h41, "clear alias");
    rd(ERP_OFS_SET, 8'h41);
    rd(ERP_OFS_CLR, 8'h41);
    wr(8'h40, 8'h7d);
    rd(8'h40, ERP_RD_ZERO);
    ck(ctrl_reg === 8'h41, "unmapped write");
  endtask : t_regs
  task automatic edge_step(input int i, input logic v, input logic [7:0] c, input bit exp, input logic alt);
    bit seen = 1'b0;
    wr(ERP_OFS_CTRL, c);
    @(negedge sys_clk);
    monitor_in[i] = v;
    repeat (10) begin
      @(negedge sys_clk);
      if (rx_cmd_req_reg === 1'b1 && !seen) begin
        seen = 1'b1;
        ck(rx_cmd_alt_int_reg === alt, "alt_int flag");
      end
    end
    ck(seen == exp, "report presence");
    repeat (20) if (rx_cmd_req_reg !== 1'b0) @(negedge sys_clk);
    ck(rx_cmd_req_reg === 1'b0, "report not cleared");
  endtask : edge_step
  task automatic t_events;
    for (int i = 0; i < 7; i++) begin
      ack_delay = i[0] ? 4'h3 : 4'h0;
      edge_step(i, 1'b1, 8'h01 << ren[i], 1'b1, i == 1);
      edge_step(i, 1'b0, ~(8'h01 << fen[i]) & 8'h7d, 1'b0, 1'b0);
      edge_step(i, 1'b1, ~(8'h01 << ren[i]) & 8'h7d, 1'b0, 1'b0);
      edge_step(i, 1'b0, 8'h01 << fen[i], 1'b1, i == 1);
    end
  endtask : t_events
  // A reset in mid-run, with a report pending, must clear the register and the report.
  task automatic t_reset;
    wr(ERP_OFS_SET, 8'h7d);
    @(negedge sys_clk);
    monitor_in[6] = ~monitor_in[6];
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    ck(ctrl_reg === ERP_CTRL_RESET && rx_cmd_req_reg === 1'b0, "mid-run reset");
    rd(ERP_OFS_CTRL, ERP_CTRL_RESET);
    repeat (2) @(negedge sys_clk);
    ck(rx_cmd_req_reg === 1'b0, "report with enables off after reset");
  endtask : t_reset
  task automatic stop_test;
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_regs();
    t_events();
    t_reset();
    stop_test();
  end
  // About 400 cycles are expected; the limit leaves ample margin.
  initial begin
    #100us;
    err_count++;
    stop_test();
  end
endmodule : erp_event_report_tb
